//--- verilog/wocfg_pkg.sv
// package: register map, field positions and timing constants of the option register bank
package wocfg_pkg;

  // =========================================================
  // register addresses (cpu byte addresses)
  localparam logic [15:0] STOP_CLOCK_CONFIG_ADDR = 16'h001d;
  localparam logic [15:0] WATCHDOG_VOLTAGE_CONFIG_ADDR = 16'h001f;
  localparam logic [15:0] CLOCK_OPTION_BYTE_ADDR = 16'hffcf;

  // =========================================================
  // reset and erased values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] OPTION_ERASED = 8'hff;
  localparam logic [7:0] OPTION_RESERVED_MASK = 8'h3f;
  localparam logic [7:0] STOP_CLOCK_WRITABLE = 8'hf9;

  // =========================================================
  // watchdog_voltage_config field positions
  localparam int WD_PERIOD_SELECT_BIT = 7;
  localparam int STOP_MODE_MONITOR_BIT = 6;
  localparam int MONITOR_RESET_DISABLE_BIT = 5;
  localparam int MAIN_SUPPLY_DISABLE_BIT = 4;
  localparam int REGULATOR_DISABLE_BIT = 3;
  localparam int SHORT_RECOVERY_BIT = 2;
  localparam int STOP_ENABLE_BIT = 1;
  localparam int WD_DISABLE_BIT = 0;

  // =========================================================
  // stop_clock_config and clock-option byte field positions
  localparam int INT_OSC_STOP_DISABLE_BIT = 7;
  localparam int RC_OSC_STOP_ENABLE_BIT = 6;
  localparam int CRYSTAL_OSC_STOP_ENABLE_BIT = 5;
  localparam int TIMEBASE_SEL_HI_BIT = 4;
  localparam int TIMEBASE_SEL_LO_BIT = 3;
  localparam int SERIAL_BAUD_SRC_BIT = 0;
  localparam int MAIN_SEL_HI_BIT = 7;
  localparam int MAIN_SEL_LO_BIT = 6;

  // =========================================================
  // timing in internal-oscillator cycles
  localparam logic [17:0] WD_SHORT_TIMEOUT = 18'h01ff0; // 2^13 - 2^4
  localparam logic [17:0] WD_LONG_TIMEOUT = 18'h3fff0; // 2^18 - 2^4
  localparam logic [12:0] STOP_SHORT_RECOVERY = 13'h0020; // 32
  localparam logic [12:0] STOP_LONG_RECOVERY = 13'h1000; // 4096

  // =========================================================
  // clock source selections
  typedef enum logic [2:0] {
    WOCFG_SRC_INTERNAL = 3'b001,
    WOCFG_SRC_RC = 3'b010,
    WOCFG_SRC_CRYSTAL = 3'b100
  } wocfg_source_type;

  // decoded option signals travelling to the rest of the chip
  typedef struct packed {
    logic [17:0] watchdog_timeout;
    logic watchdog_enable;
    logic main_monitor_enable;
    logic regulator_monitor_enable;
    logic monitor_reset_enable;
    logic monitor_stop_run;
    logic stop_instruction_enable;
    logic [12:0] stop_recovery;
  } wocfg_options_type;

  typedef struct packed {
    logic int_osc_stop_disable;
    logic rc_osc_stop_enable;
    logic crystal_osc_stop_enable;
    logic [2:0] timebase_source;
    logic timebase_valid;
    logic [2:0] main_source;
    logic main_valid;
    logic serial_from_bus_clock;
  } wocfg_clocks_type;

endpackage

//--- verilog/wocfg_once_reg.sv
// one write-once configuration register with its own lock
`timescale 1ns/1ps
module wocfg_once_reg (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic write_en,
  input wire logic [7:0] write_data,
  input wire logic [7:0] writable_mask,
  output logic [7:0] value,
  output logic locked
);

  // =========================================================
  // contents: only the first write after reset is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value <= wocfg_pkg::CONFIG_RESET;
    end else if (write_en && !locked) begin
      value <= write_data & writable_mask;
    end
  end

  // lock is private to this register, so the other one stays armed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      locked <= 1'b0;
    end else if (write_en) begin
      locked <= 1'b1;
    end
  end

endmodule

//--- verilog/wocfg_decode.sv
// decodes the clock-option byte and the stop/clock register into source selections
`timescale 1ns/1ps
module wocfg_decode (
  input wire logic [7:0] stop_clock,
  input wire logic [7:0] option_byte,
  output wocfg_pkg::wocfg_clocks_type clocks
);

  // two-bit code to one-hot source; code 00 for main and 11 for timebase are unused
  function automatic logic [2:0] main_code(input logic [1:0] code);
    if (code == 2'b01) begin
      main_code = wocfg_pkg::WOCFG_SRC_INTERNAL;
    end else if (code == 2'b10) begin
      main_code = wocfg_pkg::WOCFG_SRC_RC;
    end else if (code == 2'b11) begin
      main_code = wocfg_pkg::WOCFG_SRC_CRYSTAL;
    end else begin
      main_code = 3'h0;
    end
  endfunction

  logic [1:0] main_bits;
  logic [1:0] tb_bits;

  // =========================================================
  // field extraction and routing
  always_comb begin
    main_bits = {option_byte[wocfg_pkg::MAIN_SEL_HI_BIT],
                 option_byte[wocfg_pkg::MAIN_SEL_LO_BIT]};
    tb_bits = {stop_clock[wocfg_pkg::TIMEBASE_SEL_HI_BIT],
               stop_clock[wocfg_pkg::TIMEBASE_SEL_LO_BIT]};
    clocks.main_source = main_code(main_bits);
    clocks.main_valid = (main_bits != 2'b00);
    clocks.timebase_source = main_code(tb_bits + 2'b01);
    clocks.timebase_valid = (tb_bits != 2'b11);
    clocks.serial_from_bus_clock = stop_clock[wocfg_pkg::SERIAL_BAUD_SRC_BIT];
    clocks.int_osc_stop_disable = stop_clock[wocfg_pkg::INT_OSC_STOP_DISABLE_BIT];
    clocks.rc_osc_stop_enable = stop_clock[wocfg_pkg::RC_OSC_STOP_ENABLE_BIT];
    clocks.crystal_osc_stop_enable = stop_clock[wocfg_pkg::CRYSTAL_OSC_STOP_ENABLE_BIT];
  end

endmodule

//--- verilog/wocfg_top.sv
// option register bank: two write-once configuration registers and the clock-option byte
//
// Notes on behaviour
// - each configuration register takes only its first write after reset
// - reset clears both registers to zero and re-arms their write
// - both registers read back their contents at any time
// - stop/clock register at 001D, watchdog/voltage register at 001F
// - period select: set gives 2^13-2^4 cycles, clear gives 2^18-2^4
// - watchdog disable bit set turns the watchdog off
// - stop-mode monitor bit keeps voltage monitor alive if a detector is on
// - monitor reset disable bit blocks voltage monitor resets
// - main-supply disable bit turns off the main supply detector
// - regulator disable bit turns off the regulated supply detector
// - short recovery: 32 cycles when set, 4096 when clear
// - stop exit by reset pin always uses the long recovery
// - stop instruction is illegal unless the stop enable bit is set
// - clock-option byte lives in flash at FFCF, erased ones, low six reserved
// - option byte selects main clock: 01 internal, 10 RC, 11 crystal
// - timebase clock: 00 internal, 01 RC, 10 crystal, 11 unused
// - serial baud clock from bus clock when set, oscillator otherwise
// - oscillator stop bits halt internal or keep RC and crystal running
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module wocfg_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [7:0] FLASH_OPTION_BYTE,
  input wire logic STOP_EXIT_BY_RESET_PIN,
  output wocfg_pkg::wocfg_options_type OPTIONS,
  output wocfg_pkg::wocfg_clocks_type CLOCKS,
  output logic STOP_CLOCK_LOCKED,
  output logic WATCHDOG_VOLTAGE_LOCKED
);

  logic [7:0] stop_clock;
  logic [7:0] wd_volt;
  logic [7:0] option_byte;
  logic sel_stop_clock;
  logic sel_wd_volt;
  logic sel_option;
  logic [7:0] next_rdata;

  // =========================================================
  // address decode
  always_comb begin
    sel_stop_clock = 1'b0;
    sel_wd_volt = 1'b0;
    sel_option = 1'b0;
    if (ADDR == wocfg_pkg::STOP_CLOCK_CONFIG_ADDR) begin
      sel_stop_clock = 1'b1;
    end else if (ADDR == wocfg_pkg::WATCHDOG_VOLTAGE_CONFIG_ADDR) begin
      sel_wd_volt = 1'b1;
    end else if (ADDR == wocfg_pkg::CLOCK_OPTION_BYTE_ADDR) begin
      sel_option = 1'b1;
    end
  end

  // =========================================================
  // write-once registers, unwritable bits of stop/clock read as zero
  wocfg_once_reg u_stop_clock (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .write_en(WR && sel_stop_clock),
    .write_data(WDATA),
    .writable_mask(wocfg_pkg::STOP_CLOCK_WRITABLE),
    .value(stop_clock),
    .locked(STOP_CLOCK_LOCKED)
  );

  wocfg_once_reg u_wd_volt (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .write_en(WR && sel_wd_volt),
    .write_data(WDATA),
    .writable_mask(wocfg_pkg::OPTION_ERASED),
    .value(wd_volt),
    .locked(WATCHDOG_VOLTAGE_LOCKED)
  );

  // flash byte is not writable over this port; reserved bits forced to erased ones
  always_comb begin
    option_byte = FLASH_OPTION_BYTE | wocfg_pkg::OPTION_RESERVED_MASK;
  end

  // =========================================================
  // read data one cycle after the strobe; unmapped reads give zero
  always_comb begin
    next_rdata = 8'h00;
    if (sel_stop_clock) begin
      next_rdata = stop_clock;
    end else if (sel_wd_volt) begin
      next_rdata = wd_volt;
    end else if (sel_option) begin
      next_rdata = option_byte;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // =========================================================
  // watchdog and voltage monitor controls, registered for clean outputs
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      OPTIONS <= '0;
    end else begin
      OPTIONS.watchdog_timeout <= wd_volt[wocfg_pkg::WD_PERIOD_SELECT_BIT] ?
        wocfg_pkg::WD_SHORT_TIMEOUT : wocfg_pkg::WD_LONG_TIMEOUT;
      OPTIONS.watchdog_enable <= !wd_volt[wocfg_pkg::WD_DISABLE_BIT];
      OPTIONS.main_monitor_enable <= !wd_volt[wocfg_pkg::MAIN_SUPPLY_DISABLE_BIT];
      OPTIONS.regulator_monitor_enable <= !wd_volt[wocfg_pkg::REGULATOR_DISABLE_BIT];
      OPTIONS.monitor_reset_enable <= !wd_volt[wocfg_pkg::MONITOR_RESET_DISABLE_BIT];
      // stop-mode monitoring needs at least one detector left on
      OPTIONS.monitor_stop_run <= wd_volt[wocfg_pkg::STOP_MODE_MONITOR_BIT] &&
        !(wd_volt[wocfg_pkg::MAIN_SUPPLY_DISABLE_BIT] &&
          wd_volt[wocfg_pkg::REGULATOR_DISABLE_BIT]);
      OPTIONS.stop_instruction_enable <= wd_volt[wocfg_pkg::STOP_ENABLE_BIT];
      // reset pin exit forces long recovery so the supply monitor is back first
      OPTIONS.stop_recovery <= (wd_volt[wocfg_pkg::SHORT_RECOVERY_BIT] &&
        !STOP_EXIT_BY_RESET_PIN) ?
        wocfg_pkg::STOP_SHORT_RECOVERY : wocfg_pkg::STOP_LONG_RECOVERY;
    end
  end

  // =========================================================
  // clock routing decode
  wocfg_pkg::wocfg_clocks_type next_clocks;

  wocfg_decode u_decode (
    .stop_clock(stop_clock),
    .option_byte(option_byte),
    .clocks(next_clocks)
  );

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      CLOCKS <= '0;
    end else begin
      CLOCKS <= next_clocks;
    end
  end

endmodule

//--- tb/wocfg_assertions.sv
// checker: port-level properties of the option register bank
`timescale 1ns/1ps
module wocfg_assertions (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] FLASH_OPTION_BYTE,
  input wire logic STOP_EXIT_BY_RESET_PIN,
  input wire wocfg_pkg::wocfg_options_type OPTIONS,
  input wire wocfg_pkg::wocfg_clocks_type CLOCKS,
  input wire logic STOP_CLOCK_LOCKED,
  input wire logic WATCHDOG_VOLTAGE_LOCKED
);
  // =========================================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // =========================================================
  // bus and lock behaviour
  a_rd_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not idle");
  a_unmapped_read: assert property (RD && !(ADDR inside {16'h001d, 16'h001f, 16'hffcf})
    |=> RDATA == 8'h00) else $error("unmapped read not zero");
  a_option_read: assert property (RD && ADDR == 16'hffcf
    |=> RDATA == ($past(FLASH_OPTION_BYTE) | 8'h3f)) else $error("option byte read");
  a_first_locks: assert property (WR && ADDR == 16'h001f |=> WATCHDOG_VOLTAGE_LOCKED)
    else $error("write did not lock");
  a_lock_holds: assert property (WATCHDOG_VOLTAGE_LOCKED |=> WATCHDOG_VOLTAGE_LOCKED)
    else $error("lock dropped");
  a_lock_separate: assert property (WR && ADDR == 16'h001f && !STOP_CLOCK_LOCKED
    |=> !STOP_CLOCK_LOCKED) else $error("foreign lock");

  // =========================================================
  // decoded options, two edges after the first write; main select and pin exit one edge after their inputs
  a_wd_fields: assert property (WR && ADDR == 16'h001f
    && !WATCHDOG_VOLTAGE_LOCKED
    ##1 !STOP_EXIT_BY_RESET_PIN |=>
    OPTIONS.watchdog_timeout == ($past(WDATA[7], 2) ? 18'h01ff0 : 18'h3fff0) &&
    OPTIONS.watchdog_enable == !$past(WDATA[0], 2) &&
    OPTIONS.stop_instruction_enable == $past(WDATA[1], 2) &&
    OPTIONS.stop_recovery == ($past(WDATA[2], 2) ? 13'h0020 : 13'h1000))
    else $error("watchdog or stop fields wrong");
  a_lvi_fields: assert property (WR && ADDR == 16'h001f
    && !WATCHDOG_VOLTAGE_LOCKED
    |=> ##1 OPTIONS.monitor_reset_enable == !$past(WDATA[5], 2) &&
    OPTIONS.main_monitor_enable == !$past(WDATA[4], 2) &&
    OPTIONS.regulator_monitor_enable == !$past(WDATA[3], 2) &&
    OPTIONS.monitor_stop_run == ($past(WDATA[6], 2) &&
    !($past(WDATA[4], 2) && $past(WDATA[3], 2))))
    else $error("voltage monitor fields wrong");
  a_clock_fields: assert property (WR && ADDR == 16'h001d
    && !STOP_CLOCK_LOCKED
    |=> ##1 CLOCKS.timebase_valid == ($past(WDATA[4:3], 2) != 2'b11) &&
    CLOCKS.serial_from_bus_clock == $past(WDATA[0], 2) &&
    CLOCKS.int_osc_stop_disable == $past(WDATA[7], 2) &&
    CLOCKS.rc_osc_stop_enable == $past(WDATA[6], 2) &&
    CLOCKS.crystal_osc_stop_enable == $past(WDATA[5], 2)) else $error("clock fields wrong");
  a_main_decode: assert property ($past(RST_N)
    |-> CLOCKS.main_valid == ($past(FLASH_OPTION_BYTE[7:6]) != 2'b00)) else $error("main select");
  a_reset_long: assert property ($past(RST_N) && $past(STOP_EXIT_BY_RESET_PIN)
    |-> OPTIONS.stop_recovery == 13'h1000) else $error("pin exit not long");
endmodule

bind wocfg_top wocfg_assertions wocfg_assertions_inst (.REF_CLK, .RST_N, .ADDR, .WDATA, .WR,
  .RD, .RDATA, .FLASH_OPTION_BYTE, .STOP_EXIT_BY_RESET_PIN, .OPTIONS, .CLOCKS,
  .STOP_CLOCK_LOCKED, .WATCHDOG_VOLTAGE_LOCKED);

//--- tb/wocfg_top_test.sv
// self-checking testbench of the option register bank
`timescale 1ns/1ps
module wocfg_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] flash = 8'hff;
  logic pin = 1'b0;
  logic [7:0] rdata;
  wocfg_pkg::wocfg_options_type opts;
  wocfg_pkg::wocfg_clocks_type clks;
  logic sc_lock;
  logic wv_lock;
  int err_total = 0;
  int checks = 0;

  // =========================================================
  // clock and design
  initial begin
    forever #2.5 clk = ~clk;
  end

  wocfg_top wocfg_top_inst (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .FLASH_OPTION_BYTE(flash),
    .STOP_EXIT_BY_RESET_PIN(pin), .OPTIONS(opts), .CLOCKS(clks),
    .STOP_CLOCK_LOCKED(sc_lock), .WATCHDOG_VOLTAGE_LOCKED(wv_lock));

  // =========================================================
  // shared tasks; each bus task ends one edge later so strobes never toggle twice at once
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge clk);
  endtask

  // =========================================================
  // scenarios
  task automatic cfg_case(input logic [7:0] wv, input logic [7:0] sc);
    // short recovery only when not running from the crystal
    flash <= wv[2] ? 8'h7f : 8'hff;
    do_reset();
    bus_rd(16'h001f, 8'h00);
    check(wv_lock, 1'b0);
    bus_wr(16'h001f, wv);
    check(sc_lock, 1'b0);
    bus_rd(16'h001d, 8'h00);
    bus_wr(16'h001d, sc);
    bus_wr(16'h001f, ~wv);
    bus_wr(16'h001d, ~sc);
    bus_rd(16'h001f, wv);
    bus_rd(16'h001d, sc & 8'hf9);
    check(opts.watchdog_timeout, wv[7] ? 18'h01ff0 : 18'h3fff0);
    check(opts.stop_recovery, wv[2] ? 13'h0020 : 13'h1000);
    check(clks.main_source, wv[2] ? 3'b001 : 3'b100);
    check(clks.timebase_source, (sc[4:3] == 2'b00) ? 3'b001 :
      (sc[4:3] == 2'b01) ? 3'b010 : (sc[4:3] == 2'b10) ? 3'b100 : 3'b000);
    $display("test cfg_case %h %h done", wv, sc);
  endtask

  // keeps the short-recovery setting of the last case, so the pin must override it
  task automatic misc_case();
    flash <= 8'h80;
    pin <= 1'b1;
    bus_wr(16'h001e, 8'h5a);
    bus_wr(16'hffcf, 8'h00);
    bus_rd(16'h001e, 8'h00);
    bus_rd(16'hffcf, 8'hbf);
    check(opts.stop_recovery, 13'h1000);
    check(clks.main_source, 3'b010);
    // unused main code: no source and not valid
    flash <= 8'h00;
    bus_rd(16'hffcf, 8'h3f);
    check(clks.main_valid, 1'b0);
    check(clks.main_source, 3'b000);
    pin <= 1'b0;
    $display("test misc_case done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // =========================================================
  // main sequence and hang guard
  initial begin
    cfg_case(8'ha2, 8'he1);
    cfg_case(8'h79, 8'h08);
    cfg_case(8'h44, 8'h10);
    cfg_case(8'h3f, 8'hff);
    misc_case();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule
